// ===== design/mtirq_pkg.sv
// Package: constants and event indices for the measurement timer interrupt logic
package mtirq_pkg;
    // ------------------------------------------------------------
    // Event indices and widths
    // ------------------------------------------------------------
    localparam int unsigned NUM_EVENTS = 3;
    localparam int unsigned EV_PW      = 0;    // Pulse-width capture updated
    localparam int unsigned EV_PR      = 1;    // Period capture updated
    localparam int unsigned EV_MATCH   = 2;    // Counter reached period value
    localparam int unsigned COUNT_W    = 16;   // Counter and period width
    localparam int unsigned SYNC_STAGES = 2;   // Flops in the CPU-clock synchroniser

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [2:0] EVENT_RST = 3'h0;
    localparam logic       BIT_RST   = 1'h0;
endpackage : mtirq_pkg

// ===== design/mtirq_sync.sv
// Two-flop level synchroniser for a group of toggle signals
module mtirq_sync #(
    parameter int unsigned WIDTH = 3
) (
    input  wire logic             clk,
    input  wire logic             reset_n,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    // First stage feeds only the second stage
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;
endmodule // mtirq_sync

// ===== design/mtirq_top.sv
// Measurement timer interrupt logic: triggers, synchronisers, flags and request
module mtirq_top
    import mtirq_pkg::*;
(
    input  wire logic                         clk,
    input  wire logic                         reset_n,
    input  wire logic                         sync_mode,
    input  wire logic                         measure_clock,
    input  wire logic                         captured_pulse_width_update,
    input  wire logic                         captured_period_update,
    input  wire logic                         count_enable,
    input  wire logic [mtirq_pkg::COUNT_W-1:0] measure_counter,
    input  wire logic [mtirq_pkg::COUNT_W-1:0] measure_period_value,
    input  wire logic                         pulse_width_acquired_enable,
    input  wire logic                         period_acquired_enable,
    input  wire logic                         period_match_enable,
    input  wire logic                         pulse_width_flag_clear,
    input  wire logic                         period_flag_clear,
    input  wire logic                         period_match_flag_clear,
    output logic                              pulse_width_acquired_flag,
    output logic                              period_acquired_flag,
    output logic                              period_match_flag,
    output logic                              counter_halt,
    output logic                              irq
);
    import mtirq_pkg::*;

    // ------------------------------------------------------------
    // Event sources
    // ------------------------------------------------------------
    logic [NUM_EVENTS-1:0] event_req;
    logic [NUM_EVENTS-1:0] flag_clear;
    logic [NUM_EVENTS-1:0] flag_enable;
    logic                  match_now;

    // Match only counts while the counter is running
    assign match_now = count_enable && (measure_counter == measure_period_value);

    // Capture updates and the match form the three sources
    assign event_req[EV_PW]    = captured_pulse_width_update;
    assign event_req[EV_PR]    = captured_period_update;
    assign event_req[EV_MATCH] = match_now;

    assign flag_clear  = {period_match_flag_clear, period_flag_clear, pulse_width_flag_clear};
    assign flag_enable = {period_match_enable, period_acquired_enable,
                          pulse_width_acquired_enable};

    // ------------------------------------------------------------
    // Measure clock edge detection
    // ------------------------------------------------------------
    logic mclk_q;
    logic mclk_rise;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mclk_q <= BIT_RST;
        end else begin
            mclk_q <= measure_clock;
        end
    end

    assign mclk_rise = measure_clock && !mclk_q;

    // ------------------------------------------------------------
    // Trigger stage: one toggle per source
    // ------------------------------------------------------------
    // A toggle carries each event across; a pulse could be lost in the synchroniser.
    logic [NUM_EVENTS-1:0] pending_q;
    logic [NUM_EVENTS-1:0] toggle_q;
    logic [NUM_EVENTS-1:0] fire;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_EVENTS; gi++) begin : g_trig
            // Synchronous mode waits for a measure clock edge, asynchronous fires at once
            assign fire[gi] = (event_req[gi] || pending_q[gi])
                              && (!sync_mode || mclk_rise);

            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    pending_q[gi] <= BIT_RST;
                    toggle_q[gi]  <= BIT_RST;
                end else begin
                    pending_q[gi] <= (event_req[gi] || pending_q[gi]) && !fire[gi];
                    toggle_q[gi]  <= toggle_q[gi] ^ fire[gi];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Crossing into the CPU clock domain
    // ------------------------------------------------------------
    logic [NUM_EVENTS-1:0] toggle_sync;
    logic [NUM_EVENTS-1:0] seen_q;
    logic [NUM_EVENTS-1:0] trig_edge;

    mtirq_sync #(
        .WIDTH    (NUM_EVENTS)
    ) u_sync (
        .clk      (clk),
        .reset_n  (reset_n),
        .async_in (toggle_q),
        .sync_out (toggle_sync)
    );

    // Edge of the synchronised toggle is one event
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            seen_q <= EVENT_RST;
        end else begin
            seen_q <= toggle_sync;
        end
    end

    assign trig_edge = toggle_sync ^ seen_q;

    // ------------------------------------------------------------
    // Sticky flags and interrupt request
    // ------------------------------------------------------------
    logic [NUM_EVENTS-1:0] flag_q;
    logic [NUM_EVENTS-1:0] flag_d;
    logic                  halt_q;

    // Set wins over a clear arriving in the same cycle
    assign flag_d = trig_edge | (flag_q & ~flag_clear);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            flag_q <= EVENT_RST;
            halt_q <= BIT_RST;
        end else begin
            flag_q <= flag_d;
            halt_q <= match_now;
        end
    end

    assign pulse_width_acquired_flag = flag_q[EV_PW];
    assign period_acquired_flag      = flag_q[EV_PR];
    assign period_match_flag         = flag_q[EV_MATCH];
    assign counter_halt              = halt_q;
    // Each flag reaches the CPU only through its own enable
    assign irq = |(flag_q & flag_enable);

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    // Latencies below count the toggle flop, the two synchroniser stages and the flag flop
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    pw_async_latency_a: assert property (
        (!sync_mode && captured_pulse_width_update) |-> ##4 pulse_width_acquired_flag)
        else $error("pulse width flag not set four cycles after update");
    pr_async_latency_a: assert property (
        (!sync_mode && captured_period_update) |-> ##4 period_acquired_flag)
        else $error("period flag not set four cycles after update");
    match_flag_set_a: assert property (
        (!sync_mode && match_now) |-> ##4 period_match_flag)
        else $error("match flag not set after counter match");
    match_halt_a: assert property (
        match_now |=> counter_halt)
        else $error("halt not raised after match");
    sync_wait_a: assert property (
        (sync_mode && !mclk_rise) |=> $stable(toggle_q))
        else $error("trigger moved without measure clock edge");
    async_fire_a: assert property (
        (!sync_mode && captured_pulse_width_update) |=> $changed(toggle_q[EV_PW]))
        else $error("asynchronous trigger delayed");
    sync_path_a: assert property (
        trig_edge == ($past(toggle_q, 2) ^ $past(toggle_q, 3)))
        else $error("trigger reached flags without two synchroniser stages");
    flag_sticky_a: assert property (
        (pulse_width_acquired_flag && !pulse_width_flag_clear) |=> pulse_width_acquired_flag)
        else $error("flag dropped without clear");
    set_wins_a: assert property (
        (trig_edge[EV_PR] && period_flag_clear) |=> period_acquired_flag)
        else $error("clear beat a simultaneous set");
    irq_gate_a: assert property (
        (!pulse_width_acquired_enable && !period_acquired_enable && !period_match_enable)
        |-> !irq)
        else $error("request raised with all enables low");

    // Per-flag gating, halt release, synchronous firing and clearing
    irq_source_a: assert property (
        irq |-> |({period_match_flag, period_acquired_flag, pulse_width_acquired_flag}
                  & {period_match_enable, period_acquired_enable, pulse_width_acquired_enable}))
        else $error("request raised without an enabled flag");
    halt_drop_a: assert property (
        !match_now |=> !counter_halt)
        else $error("halt raised without a match");
    sync_fire_a: assert property (
        (sync_mode && mclk_rise && (captured_period_update || pending_q[EV_PR]))
        |=> $changed(toggle_q[EV_PR]))
        else $error("pending trigger missed the measure clock edge");
    pr_sticky_a: assert property (
        (period_acquired_flag && !period_flag_clear) |=> period_acquired_flag)
        else $error("period flag dropped without clear");
    match_sticky_a: assert property (
        (period_match_flag && !period_match_flag_clear) |=> period_match_flag)
        else $error("match flag dropped without clear");
    flag_clear_a: assert property (
        (pulse_width_acquired_flag && pulse_width_flag_clear && !trig_edge[EV_PW])
        |=> !pulse_width_acquired_flag)
        else $error("pulse width flag ignored its clear");

    pw_irq_c:    cover property (captured_pulse_width_update ##[1:20] irq);
    sync_pr_c:   cover property (sync_mode && captured_period_update ##[1:40] period_acquired_flag);
    match_clr_c: cover property (period_match_flag ##1 period_match_flag_clear ##1 !period_match_flag);
    sync_match_c: cover property (sync_mode && match_now ##[1:40] period_match_flag);
    set_clr_c:   cover property (trig_edge[EV_PR] && period_flag_clear);
endmodule // mtirq_top

// ===== testbench/tb_top.sv
// Self-checking bench for the measurement timer interrupt logic
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import mtirq_pkg::*;

    logic                clk = 1'b0;
    logic                reset_n = 1'b0;
    logic                sm = 1'b0, mclk = 1'b0, pw_upd = 1'b0, pr_upd = 1'b0, ce = 1'b0;
    logic [COUNT_W-1:0]  cnt = '0, per = 16'h0010;
    logic [2:0]          en = 3'h0, clr = 3'h0;
    wire  [2:0]          flags;
    wire                 halt, irq;
    int                  errors = 0, samples_checked = 0;
    logic [31:0]         seed = 32'd5988;
    logic                exp_halt, nxt_halt;
    int                  n;

    mtirq_top mtirq_top_i (.clk(clk), .reset_n(reset_n), .sync_mode(sm), .measure_clock(mclk),
        .captured_pulse_width_update(pw_upd), .captured_period_update(pr_upd),
        .count_enable(ce), .measure_counter(cnt), .measure_period_value(per),
        .pulse_width_acquired_enable(en[0]), .period_acquired_enable(en[1]),
        .period_match_enable(en[2]), .pulse_width_flag_clear(clr[0]),
        .period_flag_clear(clr[1]), .period_match_flag_clear(clr[2]),
        .pulse_width_acquired_flag(flags[0]), .period_acquired_flag(flags[1]),
        .period_match_flag(flags[2]), .counter_halt(halt), .irq(irq));

    // ----------------------------------------
    // Clock, random source and reporting
    // ----------------------------------------
    initial begin
        forever #50 clk = ~clk;
    end

    function automatic logic [31:0] xorshift(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task automatic check_bit(input string what, input logic exp, input logic got);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic results();
        if (errors == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // Raise one source for a single sampled cycle; the match source needs counter equal period
    task automatic request(input int s);
        @(posedge clk);
        if (s == EV_PW) pw_upd <= 1'b1;
        if (s == EV_PR) pr_upd <= 1'b1;
        if (s == EV_MATCH) begin
            ce  <= 1'b1;
            cnt <= per;
        end
        @(posedge clk);
        {pw_upd, pr_upd, ce} <= 3'h0;
        cnt <= per + 16'h0001;
        #1;
    endtask

    // Bounded wait for the flag; the synchroniser makes it land a few edges later, never sooner
    task automatic wait_flag(input int s);
        n = 0;
        while (flags[s] !== 1'b1 && n < 8) begin
            @(posedge clk);
            #1;
            n++;
        end
        check_bit("flag set", 1'b1, flags[s]);
        check_bit("flag latency", 1'b1, n >= 3 && n <= 5);
        check_bit("irq gate", en[s], irq);
    endtask

    task automatic clear(input int s);
        @(posedge clk);
        clr[s] <= 1'b1;
        @(posedge clk);
        clr <= 3'h0;
        #1;
        check_bit("flag cleared", 1'b0, flags[s]);
        check_bit("irq idle", 1'b0, irq);
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        #1;
        check_bit("flags after reset", 1'b0, |flags);
        // Every source in asynchronous mode, enable drawn at random
        for (int s = 0; s < 3; s++) begin
            seed = xorshift(seed);
            @(posedge clk);
            en <= seed[2:0];
            request(s);
            wait_flag(s);
            repeat (3) @(posedge clk);
            #1;
            check_bit("flag sticky", 1'b1, flags[s]);
            clear(s);
        end
        // Corner: the clear is high in the very cycle the period flag lands; the set wins
        request(EV_PR);
        repeat (2) @(posedge clk);
        clr[EV_PR] <= 1'b1;
        @(posedge clk);
        clr <= 3'h0;
        #1;
        check_bit("set beats clear", 1'b1, flags[EV_PR]);
        clear(EV_PR);
        // Synchronous mode: request waits for a measure clock rise
        @(posedge clk);
        en <= 3'h7;
        sm <= 1'b1;
        for (int s = 0; s < 3; s++) begin
            request(s);
            repeat (6) @(posedge clk);
            #1;
            check_bit("sync pending", 1'b0, flags[s]);
            @(posedge clk);
            mclk <= 1'b1;
            @(posedge clk);
            mclk <= 1'b0;
            #1;
            wait_flag(s);
            clear(s);
        end
        // Random counter and period values; halt mirrors the previous cycle's match
        @(posedge clk);
        sm <= 1'b0;
        exp_halt = 1'b0;
        for (int i = 0; i < 300; i++) begin
            @(posedge clk);
            seed = xorshift(seed);
            ce  <= seed[0];
            per <= {12'h000, seed[4:1]};
            cnt <= {12'h000, seed[4:2], seed[5] ? seed[1] : seed[6]};
            nxt_halt = seed[0] && (seed[5] || seed[1] == seed[6]);
            #1;
            check_bit("counter halt", exp_halt, halt);
            exp_halt = nxt_halt;
        end
        @(posedge clk);
        ce <= 1'b0;
        repeat (8) @(posedge clk);
        #1;
        check_bit("match flag before reset", 1'b1, flags[EV_MATCH]);
        // Reset in mid-run drops every flag, the halt and the request at once
        @(posedge clk);
        reset_n <= 1'b0;
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        #1;
        check_bit("outputs after reset", 1'b0, |{flags, halt, irq});
        clear(EV_MATCH);
        results();
    end

    initial begin
        #5ms;
        errors++;
        results();
    end
endmodule // tb_top
